// [hdl/halfword_divide_unit.sv]
// Halfword divide execution unit with register file writeback and Avalon-MM control port
`timescale 1ns/1ps
`default_nettype none
`include "hdu_regs.svh"

module halfword_divide_unit (
    input wire logic clk,
    input wire logic rst,
    input wire logic issueValid,
    output logic issueReady,
    input wire hdu_pkg::issueReq_t issueReq,
    input wire hdu_pkg::flags_t flagsIn,
    input wire logic intReq,
    output logic abortValid,
    output logic [31:0] abortPc,
    output logic wbValid,
    output hdu_pkg::writeback_t wb,
    output hdu_pkg::flags_t flagsOut,
    input wire logic [`HDU_ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic irq
);
    import hdu_pkg::*;

    // ****************************************
    // Helper functions
    // ****************************************
    function automatic logic [31:0] neg32(input logic [31:0] v);
        neg32 = ~v + 32'h0000_0001;
    endfunction : neg32

    function automatic logic [15:0] neg16(input logic [15:0] v);
        neg16 = ~v + 16'h0001;
    endfunction : neg16

    // Flags from a quotient; carry and saturation are only copied
    function automatic flags_t flagsFor(input logic [31:0] q, input logic ov,
                                        input logic cy, input logic saturation_flag);
        flags_t f;
        f.carry = cy;
        f.overflow = ov;
        f.sign = q[31];
        f.zero = (q == 32'h0000_0000);
        f.saturation = saturation_flag;
        flagsFor = f;
    endfunction : flagsFor

    function automatic logic regHit(input logic [`HDU_ADDR_W-1:0] a,
                                    input logic [`HDU_ADDR_W-1:0] off);
        regHit = (a == off);
    endfunction : regHit

    // ****************************************
    // State and captured instruction
    // ****************************************
    divState_t state_r;
    divState_t state_nxt;
    logic [31:0] pc_r;
    logic [4:0] quotIdx_r;
    logic [4:0] remIdx_r;
    logic quotEn_r;
    logic remEn_r;
    logic negQuot_r;
    logic negRem_r;
    logic cy_r;
    logic sat_r;
    logic [31:0] quotRes_r;
    logic [31:0] remRes_r;
    flags_t flags_r;
    logic enable_r;
    logic [31:0] count_r;
    logic readPending_r;
    logic [31:0] readdata_r;

    // ****************************************
    // Operand preparation
    // ****************************************
    wire logic isSigned = (issueReq.op != OP_UNSIGNED_3OP);
    wire logic isThreeOp = (issueReq.op != OP_SIGNED_2OP);
    wire logic [15:0] divHalf = issueReq.divisor[15:0];
    // sign taken only for signed form
    wire logic dividendNeg = isSigned && issueReq.dividend[31];
    wire logic divisorNeg = isSigned && divHalf[15];
    wire logic [31:0] magDividend = dividendNeg ? neg32(issueReq.dividend) : issueReq.dividend;
    wire logic [15:0] magDivisor = divisorNeg ? neg16(divHalf) : divHalf;
    wire logic divZero = (divHalf == 16'h0000);
    // most negative by minus one; never for unsigned
    wire logic minByMinus = isSigned && (issueReq.dividend == `HDU_MIN_NEG)
                            && (divHalf == `HDU_MINUS_ONE_HALF);
    wire logic fastPath = divZero || minByMinus;
    wire logic [31:0] fastQuot = divZero ? 32'h0000_0000 : `HDU_MIN_NEG;
    wire logic [31:0] fastRem = divZero ? issueReq.dividend : 32'h0000_0000;

    wire logic accept = issueValid && issueReady;
    wire logic startCore = accept && !fastPath;
    wire logic abortNow = (state_r == ST_RUN) && intReq;

    wire logic coreDone;
    wire logic [31:0] coreQuot;
    wire logic [15:0] coreRem;
    wire logic [31:0] coreRemWide = {16'h0000, coreRem};
    wire logic [31:0] signedQuot = negQuot_r ? neg32(coreQuot) : coreQuot;
    wire logic [31:0] signedRem = negRem_r ? neg32(coreRemWide) : coreRemWide;

    div_iter u_div (
        .clk(clk),
        .rst(rst),
        .start(startCore),
        .abort(abortNow),
        .dividend(magDividend),
        .divisor(magDivisor),
        .busy(),
        .done(coreDone),
        .quotient(coreQuot),
        .remainder(coreRem)
    );

    // ****************************************
    // Sequencing
    // ****************************************
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (accept) begin
                    state_nxt = fastPath ? ST_WB : ST_RUN;
                end
            end
            ST_RUN: begin
                if (abortNow) begin
                    state_nxt = ST_IDLE;
                end else if (coreDone) begin
                    state_nxt = ST_WB;
                end
            end
            ST_WB: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Instruction capture at issue
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pc_r <= 32'h0000_0000;
            quotIdx_r <= 5'h00;
            remIdx_r <= 5'h00;
            quotEn_r <= 1'b0;
            remEn_r <= 1'b0;
            negQuot_r <= 1'b0;
            negRem_r <= 1'b0;
            cy_r <= 1'b0;
            sat_r <= 1'b0;
        end else if (accept) begin
            pc_r <= issueReq.pc;
            quotIdx_r <= issueReq.dividendDest;
            remIdx_r <= issueReq.remainderDest;
            quotEn_r <= !(isThreeOp && (issueReq.dividendDest == issueReq.remainderDest));
            remEn_r <= isThreeOp;
            negQuot_r <= dividendNeg ^ divisorNeg;
            // Remainder follows the dividend's sign, truncating division
            negRem_r <= dividendNeg;
            cy_r <= flagsIn.carry;
            sat_r <= flagsIn.saturation;
        end
    end

    // Results and flags
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            quotRes_r <= 32'h0000_0000;
            remRes_r <= 32'h0000_0000;
            flags_r <= '0;
        end else if (accept && fastPath) begin
            quotRes_r <= fastQuot;
            remRes_r <= fastRem;
            flags_r <= flagsFor(fastQuot, 1'b1, flagsIn.carry, flagsIn.saturation);
        end else if ((state_r == ST_RUN) && coreDone && !abortNow) begin
            quotRes_r <= signedQuot;
            remRes_r <= signedRem;
            flags_r <= flagsFor(signedQuot, 1'b0, cy_r, sat_r);
        end
    end

    // ****************************************
    // Pipeline outputs
    // ****************************************
    assign issueReady = (state_r == ST_IDLE) && enable_r && !intReq;
    assign abortValid = abortNow;
    assign abortPc = pc_r;
    // nothing is written until the divide completes
    assign wbValid = (state_r == ST_WB);
    // no write path to the divisor register
    assign wb.quotEn = quotEn_r;
    assign wb.quotIdx = quotIdx_r;
    assign wb.quotData = quotRes_r;
    assign wb.remEn = remEn_r;
    assign wb.remIdx = remIdx_r;
    assign wb.remData = remRes_r;
    assign flagsOut = flags_r;

    // ****************************************
    // Avalon-MM register slave
    // ****************************************
    wire logic hitCtrl = regHit(address, `HDU_OFF_CTRL);
    wire logic hitStatus = regHit(address, `HDU_OFF_STATUS);
    wire logic hitQuot = regHit(address, `HDU_OFF_QUOT);
    wire logic hitRem = regHit(address, `HDU_OFF_REM);
    wire logic hitIrqStat = regHit(address, `HDU_OFF_IRQ_STAT);
    wire logic hitIrqEn = regHit(address, `HDU_OFF_IRQ_EN);
    wire logic hitCount = regHit(address, `HDU_OFF_COUNT);
    wire logic lowLane = byteenable[0];
    wire logic wrCtrl = write && hitCtrl && lowLane;
    wire logic wrIrqEn = write && hitIrqEn && lowLane;
    wire logic wrIrqClr = write && regHit(address, `HDU_OFF_IRQ_CLR) && lowLane;

    wire logic [`HDU_IRQ_W-1:0] irqStatus;
    wire logic [`HDU_IRQ_W-1:0] irqEnable;
    wire logic [`HDU_IRQ_W-1:0] irqEvents;

    assign irqEvents[`HDU_IRQ_DONE_BIT] = wbValid;
    assign irqEvents[`HDU_IRQ_OV_BIT] = wbValid && flags_r.overflow;
    assign irqEvents[`HDU_IRQ_ABORT_BIT] = abortNow;

    irq_sticky u_irq (
        .clk(clk),
        .rst(rst),
        .events(irqEvents),
        .clrWr(wrIrqClr),
        .enWr(wrIrqEn),
        .wrData(writedata[`HDU_IRQ_W-1:0]),
        .status(irqStatus),
        .enable(irqEnable),
        .irq(irq)
    );

    wire logic [31:0] statusWord = {28'h000_0000, flags_r.zero, flags_r.sign,
                                    flags_r.overflow, (state_r != ST_IDLE)};
    // Unmapped and write-only offsets read as zero
    wire logic [31:0] readMux =
        hitCtrl ? {31'h0000_0000, enable_r} :
        hitStatus ? statusWord :
        hitQuot ? quotRes_r :
        hitRem ? remRes_r :
        hitIrqStat ? {29'h0000_0000, irqStatus} :
        hitIrqEn ? {29'h0000_0000, irqEnable} :
        hitCount ? count_r : 32'h0000_0000;

    // One wait state on reads so read data comes from a flop
    assign waitrequest = read && !readPending_r;
    assign readdata = readdata_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            readPending_r <= 1'b0;
            readdata_r <= 32'h0000_0000;
        end else if (read && !readPending_r) begin
            readPending_r <= 1'b1;
            readdata_r <= readMux;
        end else begin
            readPending_r <= 1'b0;
        end
    end

    // Disabling only blocks new issues; a divide in flight still finishes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enable_r <= `HDU_CTRL_RESET;
        end else if (wrCtrl) begin
            enable_r <= writedata[`HDU_CTRL_EN_BIT];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_r <= 32'h0000_0000;
        end else if (wbValid) begin
            count_r <= count_r + 32'h0000_0001;
        end
    end
endmodule : halfword_divide_unit

`default_nettype wire

// [hdl/hdu_regs.svh]
// Register offsets, field positions, reset values and timing counts of the halfword divide unit
`ifndef HDU_REGS_SVH
`define HDU_REGS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define HDU_ADDR_W 8
`define HDU_OFF_CTRL 8'h00
`define HDU_OFF_STATUS 8'h04
`define HDU_OFF_QUOT 8'h08
`define HDU_OFF_REM 8'h0C
`define HDU_OFF_IRQ_STAT 8'h10
`define HDU_OFF_IRQ_EN 8'h14
`define HDU_OFF_IRQ_CLR 8'h18
`define HDU_OFF_COUNT 8'h1C

// ****************************************
// Fields and reset values
// ****************************************
`define HDU_CTRL_EN_BIT 0
`define HDU_CTRL_RESET 1'h1
`define HDU_ST_BUSY_BIT 0
`define HDU_ST_OV_BIT 1
`define HDU_ST_S_BIT 2
`define HDU_ST_Z_BIT 3
`define HDU_IRQ_W 3
`define HDU_IRQ_DONE_BIT 0
`define HDU_IRQ_OV_BIT 1
`define HDU_IRQ_ABORT_BIT 2
`define HDU_IRQ_EN_RESET 3'h0

// ****************************************
// Arithmetic constants and timing
// ****************************************
`define HDU_MIN_NEG 32'h8000_0000
`define HDU_MINUS_ONE_HALF 16'hFFFF
`define HDU_STEPS 6'h20

`endif

// [hdl/hdu_pkg.sv]
// Types shared by the halfword divide unit and its pipeline partner
`default_nettype none
package hdu_pkg;

    typedef enum logic [1:0] {
        OP_SIGNED_2OP = 2'b00,
        OP_SIGNED_3OP = 2'b01,
        OP_UNSIGNED_3OP = 2'b10
    } divOp_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_WB = 2'b10
    } divState_t;

    typedef struct packed {
        divOp_t op;
        logic [31:0] dividend;
        logic [31:0] divisor;
        logic [4:0] dividendDest;
        logic [4:0] remainderDest;
        logic [31:0] pc;
    } issueReq_t;

    typedef struct packed {
        logic quotEn;
        logic [4:0] quotIdx;
        logic [31:0] quotData;
        logic remEn;
        logic [4:0] remIdx;
        logic [31:0] remData;
    } writeback_t;

    typedef struct packed {
        logic carry;
        logic overflow;
        logic sign;
        logic zero;
        logic saturation;
    } flags_t;

endpackage : hdu_pkg

`default_nettype wire

// [hdl/div_iter.sv]
// Iterative unsigned 32-by-16 restoring divider, one quotient bit per clock
`timescale 1ns/1ps
`default_nettype none
`include "hdu_regs.svh"

module div_iter (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic abort,
    input wire logic [31:0] dividend,
    input wire logic [15:0] divisor,
    output logic busy,
    output logic done,
    output logic [31:0] quotient,
    output logic [15:0] remainder
);
    logic [31:0] quot_r;
    logic [15:0] rem_r;
    logic [15:0] div_r;
    logic [5:0] cnt_r;
    logic busy_r;

    // Shift in the next dividend bit and try to subtract
    wire logic [16:0] shifted = {rem_r, quot_r[31]};
    wire logic [16:0] trial = shifted - {1'b0, div_r};
    wire logic fits = ~trial[16];
    // Done stands one cycle after the last shift, so the result is settled
    wire logic lastStep = busy_r && (cnt_r == 6'h00);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            quot_r <= 32'h0000_0000;
            rem_r <= 16'h0000;
            div_r <= 16'h0000;
            cnt_r <= 6'h00;
            busy_r <= 1'b0;
        end else if (abort) begin
            busy_r <= 1'b0;
            cnt_r <= 6'h00;
        end else if (start) begin
            quot_r <= dividend;
            rem_r <= 16'h0000;
            div_r <= divisor;
            cnt_r <= `HDU_STEPS;
            busy_r <= 1'b1;
        end else if (busy_r) begin
            if (lastStep) begin
                busy_r <= 1'b0;
            end else begin
                rem_r <= fits ? trial[15:0] : shifted[15:0];
                quot_r <= {quot_r[30:0], fits};
                cnt_r <= cnt_r - 6'h01;
            end
        end
    end

    assign busy = busy_r;
    assign done = lastStep;
    assign quotient = quot_r;
    assign remainder = rem_r;
endmodule : div_iter

`default_nettype wire

// [hdl/irq_sticky.sv]
// Sticky event status with enable mask and write-one-to-clear, one level interrupt out
`timescale 1ns/1ps
`default_nettype none
`include "hdu_regs.svh"

module irq_sticky (
    input wire logic clk,
    input wire logic rst,
    input wire logic [`HDU_IRQ_W-1:0] events,
    input wire logic clrWr,
    input wire logic enWr,
    input wire logic [`HDU_IRQ_W-1:0] wrData,
    output logic [`HDU_IRQ_W-1:0] status,
    output logic [`HDU_IRQ_W-1:0] enable,
    output logic irq
);
    logic [`HDU_IRQ_W-1:0] status_r;
    logic [`HDU_IRQ_W-1:0] enable_r;

    genvar i;
    generate
        for (i = 0; i < `HDU_IRQ_W; i = i + 1) begin : g_bit
            // A new event in the clearing cycle survives the clear
            wire logic clrHit = clrWr && wrData[i];
            wire logic bitNxt = events[i] | (status_r[i] & ~clrHit);
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    status_r[i] <= 1'b0;
                end else begin
                    status_r[i] <= bitNxt;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enable_r <= `HDU_IRQ_EN_RESET;
        end else if (enWr) begin
            enable_r <= wrData;
        end
    end

    assign status = status_r;
    assign enable = enable_r;
    assign irq = |(status_r & enable_r);
endmodule : irq_sticky

`default_nettype wire

// [tb/hdu_properties.sv]
// Concurrent checks on the issue and writeback ports of the halfword divide unit
`timescale 1ns/1ps
`default_nettype none
`include "hdu_regs.svh"

module hdu_properties (
    input wire logic clk,
    input wire logic rst,
    input wire logic issueValid,
    input wire logic issueReady,
    input wire hdu_pkg::issueReq_t issueReq,
    input wire hdu_pkg::flags_t flagsIn,
    input wire logic intReq,
    input wire logic abortValid,
    input wire logic [31:0] abortPc,
    input wire logic wbValid,
    input wire hdu_pkg::writeback_t wb,
    input wire hdu_pkg::flags_t flagsOut
);
    import hdu_pkg::*;
    // ****
    // Operands held from acceptance
    // ****
    issueReq_t reqH;
    flags_t flagsH;
    logic busyH, fastH, accept, fastNow, signedH;
    logic [31:0] dvsExt, qS, rS, qU, rU, qExp, rExp;
    assign accept = issueValid && issueReady;
    assign fastNow = issueReq.divisor[15:0] == 16'h0000 || (issueReq.op != OP_UNSIGNED_3OP
        && issueReq.dividend == `HDU_MIN_NEG && issueReq.divisor[15:0] == `HDU_MINUS_ONE_HALF);
    assign signedH = reqH.op != OP_UNSIGNED_3OP;
    assign dvsExt = {{16{signedH & reqH.divisor[15]}}, reqH.divisor[15:0]};
    // Separate signed wires: a mixed ternary would turn the division unsigned
    assign qS = $signed(reqH.dividend) / $signed(dvsExt);
    assign rS = $signed(reqH.dividend) % $signed(dvsExt);
    assign qU = reqH.dividend / dvsExt;
    assign rU = reqH.dividend % dvsExt;
    assign qExp = signedH ? qS : qU;
    assign rExp = signedH ? rS : rU;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busyH <= 1'b0;
            fastH <= 1'b0;
            reqH <= '0;
            flagsH <= '0;
        end else if (accept) begin
            busyH <= 1'b1;
            fastH <= fastNow;
            reqH <= issueReq;
            flagsH <= flagsIn;
        end else if (wbValid || abortValid) begin
            busyH <= 1'b0;
        end
    end
    // ****
    // Properties
    // ****
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence sFastAccept;
        accept && fastNow;
    endsequence
    sequence sRunIrq;
        busyH && intReq && !wbValid;
    endsequence
    sequence sResult;
        wbValid && !fastH;
    endsequence
    AST_OVERFLOW: assert property (wbValid |-> flagsOut.overflow == fastH)
        else $error("overflow flag does not match operands");
    AST_FAST_PATH: assert property (sFastAccept |=> wbValid && flagsOut.overflow)
        else $error("overflow divide not answered with overflow");
    AST_MIN_NEG: assert property (wbValid && fastH && reqH.divisor[15:0] != 16'h0000
        |-> wb.quotData == `HDU_MIN_NEG && flagsOut.sign) else $error("min negative quotient");
    AST_QUOTIENT: assert property (sResult ##0 wb.quotEn
        |-> wb.quotData == qExp && wb.quotIdx == reqH.dividendDest) else $error("quotient wrong");
    AST_REMAINDER: assert property (sResult ##0 reqH.op != OP_SIGNED_2OP
        |-> wb.remEn && wb.remData == rExp && wb.remIdx == reqH.remainderDest)
        else $error("remainder wrong");
    AST_NO_REM_2OP: assert property (wbValid && reqH.op == OP_SIGNED_2OP
        |-> !wb.remEn && wb.quotEn) else $error("two-operand form stored a remainder");
    AST_SAME_DEST: assert property (wbValid && reqH.op != OP_SIGNED_2OP
        && reqH.dividendDest == reqH.remainderDest |-> !wb.quotEn && wb.remEn)
        else $error("shared destination did not keep the remainder");
    AST_SIGN_ZERO: assert property (sResult |-> flagsOut.sign == qExp[31]
        && flagsOut.zero == (qExp == 32'h0)) else $error("sign or zero flag wrong");
    AST_KEEP_FLAGS: assert property (wbValid |-> flagsOut.carry == flagsH.carry
        && flagsOut.saturation == flagsH.saturation) else $error("carry or saturation changed");
    AST_ABORT_NOW: assert property (sRunIrq |-> abortValid && abortPc == reqH.pc)
        else $error("interrupt did not abort with restart address");
    AST_ABORT_QUIET: assert property (abortValid |=> !wbValid [*2])
        else $error("aborted divide wrote back");
endmodule : hdu_properties

bind halfword_divide_unit hdu_properties chk (.clk(clk), .rst(rst), .issueValid(issueValid),
    .issueReady(issueReady), .issueReq(issueReq), .flagsIn(flagsIn), .intReq(intReq),
    .abortValid(abortValid), .abortPc(abortPc), .wbValid(wbValid), .wb(wb), .flagsOut(flagsOut));
`default_nettype wire

// [tb/rf_model.sv]
// Register file and interrupt entry model facing the divide unit
`timescale 1ns/1ps
`default_nettype none

module rf_model (
    input wire logic clk,
    input wire logic wbValid,
    input wire hdu_pkg::writeback_t wb,
    input wire logic abortValid,
    input wire logic [31:0] abortPc
);
    import hdu_pkg::*;
    logic [31:0] regs [32];
    logic [31:0] savedPc = 32'h0;
    // ****
    // Writeback and interrupt entry
    // ****
    // Remainder lands last, so a shared index ends up holding it
    always @(posedge clk) begin
        if (wbValid && wb.quotEn && wb.quotIdx != 5'h0) regs[wb.quotIdx] <= wb.quotData;
        if (wbValid && wb.remEn && wb.remIdx != 5'h0) regs[wb.remIdx] <= wb.remData;
        if (abortValid) savedPc <= abortPc;
    end
endmodule : rf_model
`default_nettype wire

// [tb/halfword_divide_unit_bench.sv]
// Directed bench for the halfword divide unit
`timescale 1ns/1ps
`default_nettype none
`include "hdu_regs.svh"
`define CHK(a, b) begin cmpCount++; if ((a) !== (b)) begin nErrors++; \
    $display("ERROR %0t: got %h want %h", $time, (a), (b)); end end

module halfword_divide_unit_bench;
    import hdu_pkg::*;
    logic clk, rst, issueValid, issueReady, intReq, abortValid, wbValid;
    logic read, write, waitrequest, irq;
    issueReq_t issueReq;
    flags_t flagsIn, flagsOut;
    writeback_t wb;
    logic [31:0] abortPc, writedata, readdata;
    logic [`HDU_ADDR_W-1:0] address;
    logic [3:0] byteenable;
    int nErrors, cmpCount;
    halfword_divide_unit uut (.clk(clk), .rst(rst), .issueValid(issueValid),
        .issueReady(issueReady), .issueReq(issueReq), .flagsIn(flagsIn), .intReq(intReq),
        .abortValid(abortValid), .abortPc(abortPc), .wbValid(wbValid), .wb(wb),
        .flagsOut(flagsOut), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .irq(irq));
    rf_model pm (.clk(clk), .wbValid(wbValid), .wb(wb), .abortValid(abortValid),
        .abortPc(abortPc));
    // ****
    // Clock, watchdog and verdict
    // ****
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        timeout();
    end
    task summarize;
        $display("Comparisons %0d, errors %0d", cmpCount, nErrors);
        if (nErrors == 0 && cmpCount > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    task timeout;
        nErrors++;
        $display("ERROR %0t: wait limit reached", $time);
        summarize();
    endtask : timeout
    // ****
    // Bus and issue tasks
    // ****
    task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int i;
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (waitrequest !== 1'b0 && i < 20);
        if (waitrequest !== 1'b0) timeout();
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask : av
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        av(1'b1, a, d, q);
    endtask : wr
    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        av(1'b0, a, 32'h0, q);
        `CHK(q, e)
    endtask : rdChk
    task automatic issue(input divOp_t op, input logic [31:0] dvd, dvs, pc,
                         input logic [4:0] dd, rr, input logic [1:0] cs);
        int i;
        @(posedge clk);
        issueReq <= '{op, dvd, dvs, dd, rr, pc};
        flagsIn <= '{cs[1], 1'b1, 1'b1, 1'b1, cs[0]};
        issueValid <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (issueReady !== 1'b1 && i < 50);
        if (issueReady !== 1'b1) timeout();
        issueValid <= 1'b0;
    endtask : issue
    // Fl holds the expected overflow flag above a flag that enables quotient checks
    task automatic runCase(input divOp_t op, input logic [31:0] dvd, dvs, q, r,
                           input logic [4:0] dd, rr, input logic [1:0] fl);
        int i;
        pm.regs[1] = dvs;
        pm.regs[dd] = dvd; // destination is never the zero register
        if (rr != dd) pm.regs[rr] = 32'h0BAD_0BAD;
        issue(op, dvd, dvs, 32'h100, dd, rr, dvd[1:0]);
        i = 0;
        do begin
            @(negedge clk);
            i++;
        end while (wbValid !== 1'b1 && i < 60);
        if (i >= 60) timeout();
        @(posedge clk);
        #1;
        `CHK(pm.regs[1], dvs)
        `CHK(flagsOut.overflow, fl[1])
        `CHK({flagsOut.carry, flagsOut.saturation}, dvd[1:0])
        if (fl[0]) begin
            `CHK(pm.regs[dd], (dd == rr) ? r : q)
            `CHK(flagsOut.sign, q[31])
            `CHK(flagsOut.zero, (q == 32'h0))
            if (op != OP_SIGNED_2OP && dd != rr) `CHK(pm.regs[rr], r)
        end
        if (op == OP_SIGNED_2OP) `CHK(pm.regs[rr], 32'h0BAD_0BAD)
    endtask : runCase
    // ****
    // Scenarios
    // ****
    initial begin
        rst = 1'b1;
        issueValid = 1'b0;
        issueReq = '0;
        flagsIn = '0;
        intReq = 1'b0;
        address = '0;
        read = 1'b0;
        write = 1'b0;
        writedata = '0;
        byteenable = 4'hF;
        nErrors = 0;
        cmpCount = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rdChk(`HDU_OFF_CTRL, 32'h1);
        rdChk(`HDU_OFF_IRQ_EN, 32'h0);
        rdChk(8'h20, 32'h0);
        wr(`HDU_OFF_IRQ_EN, 32'h7);
        runCase(OP_SIGNED_2OP, 32'h64, 32'hFFFF_0007, 32'hE, 32'h0, 5'h2, 5'h5, 2'h1);
        runCase(OP_SIGNED_3OP, 32'hFFFF_FF9C, 32'hABCD_0007, 32'hFFFF_FFF2, 32'hFFFF_FFFE,
                5'h2, 5'h3, 2'h1);
        runCase(OP_SIGNED_2OP, 32'h8000_0000, 32'h1234_FFFF, 32'h8000_0000, 32'h0,
                5'h2, 5'h5, 2'h3);
        runCase(OP_UNSIGNED_3OP, 32'hFFFF_FFFF, 32'hFFFF, 32'h1_0001, 32'h0,
                5'h2, 5'h3, 2'h1);
        runCase(OP_UNSIGNED_3OP, 32'h8000_0000, 32'hFFFF, 32'h8000, 32'h8000,
                5'h2, 5'h3, 2'h1);
        runCase(OP_UNSIGNED_3OP, 32'h5, 32'h5555_0000, 32'h0, 32'h0, 5'h2, 5'h3, 2'h2);
        runCase(OP_SIGNED_2OP, 32'h7, 32'hFFFF_0000, 32'h0, 32'h0, 5'h2, 5'h5, 2'h2);
        runCase(OP_SIGNED_3OP, 32'h11, 32'h5, 32'h3, 32'h2, 5'h4, 5'h4, 2'h1);
        runCase(OP_SIGNED_3OP, 32'h0, 32'h3, 32'h0, 32'h0, 5'h2, 5'h3, 2'h1);
        rdChk(`HDU_OFF_STATUS, 32'h8);
        rdChk(`HDU_OFF_IRQ_STAT, 32'h3);
        `CHK(irq, 1'b1)
        @(posedge clk);
        intReq <= 1'b1;
        @(negedge clk);
        `CHK(issueReady, 1'b0)
        @(posedge clk);
        intReq <= 1'b0;
        pm.regs[1] = 32'h7;
        pm.regs[2] = 32'h3E8;
        issue(OP_SIGNED_3OP, 32'h3E8, 32'h7, 32'hA40, 5'h2, 5'h3, 2'h0);
        repeat (5) @(posedge clk);
        intReq <= 1'b1;
        @(negedge clk);
        `CHK(abortValid, 1'b1)
        `CHK(abortPc, 32'hA40)
        @(posedge clk);
        intReq <= 1'b0;
        repeat (40) @(posedge clk);
        `CHK({pm.regs[1], pm.regs[2]}, {32'h7, 32'h3E8})
        `CHK(pm.savedPc, 32'hA40)
        rdChk(`HDU_OFF_IRQ_STAT, 32'h7);
        runCase(OP_SIGNED_3OP, 32'h3E8, 32'h7, 32'h8E, 32'h6, 5'h2, 5'h3, 2'h1);
        wr(`HDU_OFF_IRQ_CLR, 32'h7);
        rdChk(`HDU_OFF_IRQ_STAT, 32'h0);
        rdChk(`HDU_OFF_IRQ_CLR, 32'h0);
        `CHK(irq, 1'b0)
        wr(`HDU_OFF_IRQ_EN, 32'h0);
        runCase(OP_UNSIGNED_3OP, 32'h9, 32'h3, 32'h3, 32'h0, 5'h2, 5'h3, 2'h1);
        rdChk(`HDU_OFF_IRQ_STAT, 32'h1);
        `CHK(irq, 1'b0)
        wr(`HDU_OFF_IRQ_EN, 32'h1);
        @(negedge clk);
        `CHK(irq, 1'b1)
        wr(`HDU_OFF_CTRL, 32'h0);
        @(negedge clk);
        `CHK(issueReady, 1'b0)
        wr(`HDU_OFF_CTRL, 32'h1);
        // Without the low byte lane the enable must stay set
        byteenable <= 4'hE;
        wr(`HDU_OFF_CTRL, 32'h0);
        byteenable <= 4'hF;
        rdChk(`HDU_OFF_CTRL, 32'h1);
        rdChk(`HDU_OFF_COUNT, 32'hB);
        summarize();
    end
endmodule : halfword_divide_unit_bench
`default_nettype wire
